//--- inc/dwp_pkg.sv
package dwp_pkg;
  // =====================================================
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  // =====================================================
  // Field layout
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int CLOSE_BIT = 10;
  localparam int DATA_W = 16;
  localparam int MASK_W = DATA_W / 8;
  localparam int CNT_W = 6;
  // =====================================================
  // Timing in clocks
  localparam int ADDITIVE_LATENCY = 0;
  localparam int COLUMN_LATENCY = 5;
  localparam int WRITE_LATENCY = ADDITIVE_LATENCY + COLUMN_LATENCY - 1;
  localparam int WRITE_TO_READ_DELAY = 2;
  localparam int WRITE_RECOVERY_TIME = 3;
  localparam int READ_TO_PRECHARGE_TIME = 2;
  localparam int PRECHARGE_PERIOD = 3;
  localparam int ROW_ACTIVE_MIN_TIME = 8;
  localparam int ROW_CYCLE_TIME = 11;
  localparam int ROW_TO_COL_TIME = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
endpackage

//--- rtl/dwp_ctrl.sv
`timescale 1ns/100ps
// How it works
// [RULE_01] Write data goes out write latency clocks after the write command.
// [RULE_02] A read waits column latency minus one plus half burst plus turnaround.
// [RULE_03] Writes may issue every half burst clocks, gapless, any open bank.
// [RULE_04] Only eight-beat writes are interrupted, on four-beat boundary, by writes.
// [RULE_05] An interrupting write goes exactly two clocks after the prior write.
// [RULE_06] Writes with auto close are never interrupted; the interrupter may close.
// [RULE_07] Spacings use programmed burst length even when a burst was cut short.
// [RULE_08] One mask bit per eight data bits, timed like data, none on reads.
// [RULE_09] Precharge is chip select, row strobe, write enable low, column high.
// [RULE_10] Bit ten high closes all banks; low, bank bits pick one bank.
// [RULE_11] Precharge after read waits additive latency plus half burst and row active.
// [RULE_12] Read to precharge time counts from the last four-bit prefetch.
// [RULE_13] Precharge after write waits write latency plus half burst plus recovery.
// [RULE_14] Bit ten high on a read or write selects auto close.
// [RULE_15] Device starts read auto close at additive plus half burst, held off.
// [RULE_16] Device precharge starts no earlier than two clocks after last prefetch.
// [RULE_17] Activate after read auto close waits precharge period and row cycle.
// [RULE_18] Activate after write auto close waits recovery plus precharge and row cycle.
// [RULE_19] Device holds auto close until row active time is met.
// [RULE_20] Per-bank counters block commands to a bank until they expire.
module dwp_ctrl (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Mode
  input wire logic burst8_i,
  // User request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [3:0] req_cmd_i,
  input wire logic [dwp_pkg::BANK_W-1:0] req_bank_i,
  input wire logic [dwp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic req_interrupt_i,
  // Write data, one beat per clock per pin edge pair
  input wire logic [dwp_pkg::DATA_W-1:0] wr_data_i,
  input wire logic [dwp_pkg::MASK_W-1:0] wr_mask_i,
  output logic wr_data_take_o,
  // Memory pins
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [dwp_pkg::BANK_W-1:0] bank_o,
  output logic [dwp_pkg::ADDR_W-1:0] addr_o,
  output logic [dwp_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic [dwp_pkg::MASK_W-1:0] write_mask_pin_o
);
  localparam int NB = dwp_pkg::NUM_BANKS;
  localparam int CW = dwp_pkg::CNT_W;
  localparam int HB4 = 2;
  localparam int HB8 = 4;
  localparam int PIPE = 16;

  typedef logic [CW-1:0] dwp_cnt_t;

  function automatic dwp_cnt_t dwp_dec(input dwp_cnt_t c);
    dwp_dec = (c == dwp_pkg::CNT_ZERO) ? c : c - dwp_pkg::CNT_ONE;
  endfunction

  function automatic dwp_cnt_t dwp_max(input dwp_cnt_t a, input int b);
    dwp_max = (a > CW'(b)) ? a : CW'(b);
  endfunction

  // =====================================================
  // Timers
  dwp_cnt_t pre_ok_reg [NB], pre_ok_next [NB];
  dwp_cnt_t act_ok_reg [NB], act_ok_next [NB];
  dwp_cnt_t col_ok_reg [NB], col_ok_next [NB];
  logic [NB-1:0] open_reg, open_next;
  logic [NB-1:0] ap_reg, ap_next;
  dwp_cnt_t rd_ok_reg, rd_ok_next;
  dwp_cnt_t wr_ok_reg, wr_ok_next;
  dwp_cnt_t wr_age_reg, wr_age_next;
  logic last_wr_ap_reg, last_wr_ap_next;
  logic [PIPE-1:0] beat_reg, beat_next;
  logic [3:0] cmd_reg, cmd_next;
  logic [dwp_pkg::BANK_W-1:0] bank_reg, bank_next;
  logic [dwp_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [dwp_pkg::DATA_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic [dwp_pkg::MASK_W-1:0] mask_reg, mask_next;

  int hb;
  logic legal;
  logic take;
  logic close_all;
  logic interrupting;

  always_comb begin
    hb = burst8_i ? HB8 : HB4;
    close_all = req_addr_i[dwp_pkg::CLOSE_BIT];
    interrupting = burst8_i && req_interrupt_i; // see [RULE_04]
    legal = 1'b0;
    unique case (req_cmd_i)
      dwp_pkg::CMD_ACT: legal = !open_reg[req_bank_i]
          && act_ok_reg[req_bank_i] == dwp_pkg::CNT_ZERO; // see [RULE_17] see [RULE_18]
      dwp_pkg::CMD_RD: legal = open_reg[req_bank_i] && !ap_reg[req_bank_i]
          && col_ok_reg[req_bank_i] == dwp_pkg::CNT_ZERO
          && rd_ok_reg == dwp_pkg::CNT_ZERO; // see [RULE_02] see [RULE_04]
      dwp_pkg::CMD_WR: legal = open_reg[req_bank_i] && !ap_reg[req_bank_i]
          && col_ok_reg[req_bank_i] == dwp_pkg::CNT_ZERO
          && (interrupting ? (wr_age_reg == CW'(2) && !last_wr_ap_reg) // see [RULE_05] see [RULE_06]
                           : wr_ok_reg == dwp_pkg::CNT_ZERO); // see [RULE_03]
      dwp_pkg::CMD_PRE: legal = close_all // see [RULE_10]
          ? (pre_ok_reg[0] == dwp_pkg::CNT_ZERO && pre_ok_reg[1] == dwp_pkg::CNT_ZERO
             && pre_ok_reg[2] == dwp_pkg::CNT_ZERO && pre_ok_reg[3] == dwp_pkg::CNT_ZERO
             && ap_reg == '0)
          : (pre_ok_reg[req_bank_i] == dwp_pkg::CNT_ZERO && !ap_reg[req_bank_i]);
      dwp_pkg::CMD_NOP: legal = 1'b1;
      default: legal = 1'b0;
    endcase
    // Read or precharge may not cut an eight-beat write still in flight
    if ((req_cmd_i == dwp_pkg::CMD_RD || req_cmd_i == dwp_pkg::CMD_PRE)
        && wr_ok_reg != dwp_pkg::CNT_ZERO)
      legal = 1'b0; // see [RULE_04]
    take = clk_en_i && req_valid_i && legal;
  end

  assign req_ready_o = legal;
  assign wr_data_take_o = clk_en_i && beat_reg[0];

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      pre_ok_next[b] = dwp_dec(pre_ok_reg[b]); // see [RULE_20]
      act_ok_next[b] = dwp_dec(act_ok_reg[b]);
      col_ok_next[b] = dwp_dec(col_ok_reg[b]);
    end
    open_next = open_reg;
    ap_next = ap_reg;
    // Precharge period runs from the real internal start, which row active may push out
    for (int b = 0; b < NB; b++)
      if (ap_reg[b] && pre_ok_reg[b] == dwp_pkg::CNT_ZERO) begin
        ap_next[b] = 1'b0;
        open_next[b] = 1'b0;
        act_ok_next[b] = dwp_max(act_ok_next[b], dwp_pkg::PRECHARGE_PERIOD - 1); // see [RULE_17]
      end
    rd_ok_next = dwp_dec(rd_ok_reg);
    wr_ok_next = dwp_dec(wr_ok_reg);
    wr_age_next = (wr_age_reg == dwp_pkg::CNT_ZERO) ? wr_age_reg : wr_age_reg + dwp_pkg::CNT_ONE;
    if (wr_age_reg > CW'(8))
      wr_age_next = dwp_pkg::CNT_ZERO;
    last_wr_ap_next = last_wr_ap_reg;
    beat_next = {1'b0, beat_reg[PIPE-1:1]};
    cmd_next = dwp_pkg::CMD_NOP;
    bank_next = bank_reg;
    addr_next = addr_reg;
    if (take) begin
      cmd_next = req_cmd_i;
      bank_next = req_bank_i;
      addr_next = req_addr_i;
      unique case (req_cmd_i)
        dwp_pkg::CMD_ACT: begin
          open_next[req_bank_i] = 1'b1;
          col_ok_next[req_bank_i] = CW'(dwp_pkg::ROW_TO_COL_TIME - 1);
          pre_ok_next[req_bank_i] = CW'(dwp_pkg::ROW_ACTIVE_MIN_TIME - 1); // see [RULE_11]
          act_ok_next[req_bank_i] = CW'(dwp_pkg::ROW_CYCLE_TIME - 1);
        end
        dwp_pkg::CMD_RD: begin
          // Prefetch point: AL for four beats, AL+2 for eight
          pre_ok_next[req_bank_i] = dwp_max(pre_ok_reg[req_bank_i],
              dwp_max(CW'(dwp_pkg::ADDITIVE_LATENCY + hb - 1),
                      dwp_pkg::ADDITIVE_LATENCY + (burst8_i ? 2 : 0)
                      + dwp_pkg::READ_TO_PRECHARGE_TIME - 1)); // see [RULE_11] see [RULE_12]
          if (req_addr_i[dwp_pkg::CLOSE_BIT]) begin
            ap_next[req_bank_i] = 1'b1; // see [RULE_14]
            act_ok_next[req_bank_i] = dwp_max(act_ok_reg[req_bank_i],
                dwp_pkg::ADDITIVE_LATENCY + (burst8_i ? 2 : 0)
                + dwp_pkg::READ_TO_PRECHARGE_TIME + dwp_pkg::PRECHARGE_PERIOD - 1); // see [RULE_17]
          end
          wr_ok_next = CW'(hb - 1);
        end
        dwp_pkg::CMD_WR: begin
          // Programmed length, not the cut burst
          pre_ok_next[req_bank_i] = dwp_max(pre_ok_reg[req_bank_i],
              dwp_pkg::WRITE_LATENCY + hb + dwp_pkg::WRITE_RECOVERY_TIME - 1); // see [RULE_07] see [RULE_13]
          if (req_addr_i[dwp_pkg::CLOSE_BIT]) begin
            ap_next[req_bank_i] = 1'b1; // see [RULE_14]
            act_ok_next[req_bank_i] = dwp_max(act_ok_reg[req_bank_i],
                dwp_pkg::WRITE_LATENCY + hb + dwp_pkg::WRITE_RECOVERY_TIME
                + dwp_pkg::PRECHARGE_PERIOD - 1); // see [RULE_18]
          end
          rd_ok_next = CW'(dwp_pkg::COLUMN_LATENCY - 1 + hb
              + dwp_pkg::WRITE_TO_READ_DELAY - 1); // see [RULE_02]
          wr_ok_next = CW'(hb - 1); // see [RULE_03]
          wr_age_next = dwp_pkg::CNT_ONE;
          last_wr_ap_next = req_addr_i[dwp_pkg::CLOSE_BIT];
          // One pulse per beat pair; an interrupting write takes over the cut tail slots
          for (int k = 0; k < HB8; k++)
            if (k < hb)
              beat_next[dwp_pkg::WRITE_LATENCY + k - 1] = 1'b1; // see [RULE_01]
        end
        dwp_pkg::CMD_PRE: begin
          for (int b = 0; b < NB; b++)
            if (close_all || b == int'(req_bank_i)) begin // see [RULE_10]
              open_next[b] = 1'b0;
              act_ok_next[b] = dwp_max(act_ok_reg[b], dwp_pkg::PRECHARGE_PERIOD - 1);
            end
        end
        default: ;
      endcase
    end
    dq_oe_next = beat_reg[0];
    dq_next = beat_reg[0] ? wr_data_i : dq_reg;
    mask_next = beat_reg[0] ? wr_mask_i : '0; // see [RULE_08]
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int b = 0; b < NB; b++) begin
        pre_ok_reg[b] <= dwp_pkg::CNT_ZERO;
        act_ok_reg[b] <= dwp_pkg::CNT_ZERO;
        col_ok_reg[b] <= dwp_pkg::CNT_ZERO;
      end
      open_reg <= '0;
      ap_reg <= '0;
      rd_ok_reg <= dwp_pkg::CNT_ZERO;
      wr_ok_reg <= dwp_pkg::CNT_ZERO;
      wr_age_reg <= dwp_pkg::CNT_ZERO;
      last_wr_ap_reg <= 1'b0;
      beat_reg <= '0;
      cmd_reg <= dwp_pkg::CMD_DESEL;
      bank_reg <= '0;
      addr_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      mask_reg <= '0;
    end else if (clk_en_i) begin
      pre_ok_reg <= pre_ok_next;
      act_ok_reg <= act_ok_next;
      col_ok_reg <= col_ok_next;
      open_reg <= open_next;
      ap_reg <= ap_next;
      rd_ok_reg <= rd_ok_next;
      wr_ok_reg <= wr_ok_next;
      wr_age_reg <= wr_age_next;
      last_wr_ap_reg <= last_wr_ap_next;
      beat_reg <= beat_next;
      cmd_reg <= cmd_next;
      bank_reg <= bank_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      mask_reg <= mask_next;
    end
  end

  // Command pins registered; precharge code encodes [RULE_09]
  assign cs_n_o = cmd_reg[3]; // see [RULE_09]
  assign ras_n_o = cmd_reg[2];
  assign cas_n_o = cmd_reg[1];
  assign we_n_o = cmd_reg[0];
  assign bank_o = bank_reg;
  assign addr_o = addr_reg;
  assign dq_o = dq_reg;
  assign dq_oe_o = dq_oe_reg;
  assign write_mask_pin_o = mask_reg;
endmodule // dwp_ctrl

//--- bench/dwp_ctrl_assertions.sv
`timescale 1ns/100ps
module dwp_ctrl_assertions (
  input wire logic ref_clk_i, rst_n_i, burst8_i, wr_data_take_o, dq_oe_o,
  input wire logic cs_n_o, ras_n_o, cas_n_o, we_n_o,
  input wire logic [1:0] bank_o, wr_mask_i, write_mask_pin_o,
  input wire logic [12:0] addr_o,
  input wire logic [15:0] wr_data_i, dq_o
);
  localparam int TAKE_DLY = dwp_pkg::WRITE_LATENCY - 1;
  logic wr, rd, pre, act, ap_reg, ap_next;
  logic [2:0] half;
  logic [5:0] wr_age_reg, wr_age_next, rd_age_reg, rd_age_next;
  logic [1:0] wr_bank_reg, wr_bank_next, rd_bank_reg, rd_bank_next;
  // ====
  // Ages saturate so old history never trips a check
  always_comb begin
    wr = {cs_n_o, ras_n_o, cas_n_o, we_n_o} == dwp_pkg::CMD_WR;
    rd = {cs_n_o, ras_n_o, cas_n_o, we_n_o} == dwp_pkg::CMD_RD;
    pre = {cs_n_o, ras_n_o, cas_n_o, we_n_o} == dwp_pkg::CMD_PRE;
    act = {cs_n_o, ras_n_o, cas_n_o, we_n_o} == dwp_pkg::CMD_ACT;
    half = burst8_i ? 3'h4 : 3'h2;
    wr_age_next = wr ? 6'h01 : wr_age_reg + {5'h00, wr_age_reg != 6'h3f};
    rd_age_next = rd ? 6'h01 : rd_age_reg + {5'h00, rd_age_reg != 6'h3f};
    wr_bank_next = wr ? bank_o : wr_bank_reg;
    rd_bank_next = rd ? bank_o : rd_bank_reg;
    ap_next = wr ? addr_o[10] : ap_reg;
  end
  always_ff @(posedge ref_clk_i) begin
    wr_age_reg <= rst_n_i ? wr_age_next : 6'h3f;
    rd_age_reg <= rst_n_i ? rd_age_next : 6'h3f;
    wr_bank_reg <= wr_bank_next;
    rd_bank_reg <= rd_bank_next;
    ap_reg <= ap_next;
  end
  // ====
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_wr_data_lat: assert property (
    wr |-> ##TAKE_DLY wr_data_take_o ##1 dq_oe_o)
    else $error("write beats late or early");
  a_wr_spacing: assert property (
    wr |-> wr_age_reg >= 2 && !(burst8_i && wr_age_reg == 3))
    else $error("write spacing wrong");
  a_no_ap_intr: assert property (wr && burst8_i && wr_age_reg == 2 |-> !ap_reg)
    else $error("auto close write cut");
  a_wr_to_rd: assert property (
    rd |-> wr_age_reg >= dwp_pkg::COLUMN_LATENCY - 1 + half + dwp_pkg::WRITE_TO_READ_DELAY)
    else $error("read too soon after write");
  a_wr_to_pre: assert property (
    pre && (addr_o[10] || bank_o == wr_bank_reg) |->
    wr_age_reg >= dwp_pkg::WRITE_LATENCY + half + dwp_pkg::WRITE_RECOVERY_TIME)
    else $error("precharge too soon after write");
  a_rd_to_pre: assert property (
    pre && (addr_o[10] || bank_o == rd_bank_reg) |->
    rd_age_reg >= dwp_pkg::ADDITIVE_LATENCY + half && rd_age_reg >= dwp_pkg::ADDITIVE_LATENCY
    + (burst8_i ? 2 : 0) + dwp_pkg::READ_TO_PRECHARGE_TIME)
    else $error("precharge too soon after read");
  a_wap_to_act: assert property (
    act && ap_reg && bank_o == wr_bank_reg |-> wr_age_reg >=
    dwp_pkg::WRITE_LATENCY + half + dwp_pkg::WRITE_RECOVERY_TIME + dwp_pkg::PRECHARGE_PERIOD)
    else $error("activate too soon after closing write");
  a_mask_timing: assert property (
    dq_oe_o |-> $past(wr_data_take_o) && dq_o ==
    $past(wr_data_i) && write_mask_pin_o == $past(wr_mask_i))
    else $error("mask or data not timed with beat");
  cover property (wr && burst8_i && wr_age_reg == 2);
  cover property (pre && addr_o[10]);
  cover property (rd && addr_o[10]);
endmodule // dwp_ctrl_assertions
bind dwp_ctrl dwp_ctrl_assertions i_dwp_ctrl_assertions (.*);

//--- bench/dwp_dram_model.sv
`timescale 1ns/100ps
module dwp_dram_model (
  input wire logic ref_clk_i, rst_n_i, burst8_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dq_oe_i,
  input wire logic [1:0] bank_i, mask_i,
  input wire logic [12:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [3:0] open_o,
  output logic [7:0] beats_o,
  output logic [15:0] mem_o
);
  int close_in [4];
  int act_age [4];
  int half, rd_wait;
  logic [3:0] cmd;
  assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  // ====
  // Behavioural bank state, checked by the bench
  always @(posedge ref_clk_i) begin
    half = burst8_i ? 4 : 2;
    rd_wait = (burst8_i ? 2 : 0) + dwp_pkg::READ_TO_PRECHARGE_TIME;
    if (!rst_n_i) begin
      open_o <= 4'h0;
      beats_o <= 8'h00;
      mem_o <= 16'h0000;
      close_in = '{0, 0, 0, 0};
      act_age = '{0, 0, 0, 0};
    end else begin
      for (int b = 0; b < 4; b++) begin
        act_age[b]++;
        if (close_in[b] > 1) close_in[b]--;
        else if (close_in[b] == 1 && act_age[b] >= dwp_pkg::ROW_ACTIVE_MIN_TIME) begin
          open_o[b] <= 1'b0;
          close_in[b] = 0;
        end
      end
      if (cmd == dwp_pkg::CMD_ACT) begin
        open_o[bank_i] <= 1'b1;
        act_age[bank_i] = 0;
      end
      if (cmd == dwp_pkg::CMD_PRE && addr_i[10]) open_o <= 4'h0;
      if (cmd == dwp_pkg::CMD_PRE && !addr_i[10]) open_o[bank_i] <= 1'b0;
      if (cmd == dwp_pkg::CMD_RD && addr_i[10])
        close_in[bank_i] = dwp_pkg::ADDITIVE_LATENCY + ((half > rd_wait) ? half : rd_wait);
      if (cmd == dwp_pkg::CMD_WR && addr_i[10])
        close_in[bank_i] = dwp_pkg::WRITE_LATENCY + half + dwp_pkg::WRITE_RECOVERY_TIME;
      // One count per beat pair on the data pins
      if (dq_oe_i) begin
        beats_o <= beats_o + 8'h01;
        mem_o[7:0] <= mask_i[0] ? mem_o[7:0] : dq_i[7:0];
        mem_o[15:8] <= mask_i[1] ? mem_o[15:8] : dq_i[15:8];
      end
    end
  end
endmodule // dwp_dram_model

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] C_ACT = dwp_pkg::CMD_ACT;
  localparam logic [3:0] C_WR = dwp_pkg::CMD_WR;
  localparam logic [3:0] C_RD = dwp_pkg::CMD_RD;
  localparam logic [3:0] C_PRE = dwp_pkg::CMD_PRE;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, burst8_i = 1'b0;
  logic req_valid_i = 1'b0, req_interrupt_i = 1'b0;
  logic [3:0] req_cmd_i = dwp_pkg::CMD_NOP, open;
  logic [1:0] req_bank_i = 2'h0, wr_mask_i = 2'h1, bank_o, write_mask_pin_o;
  logic [12:0] req_addr_i = 13'h0000, addr_o;
  logic [15:0] wr_data_i = 16'ha5c3, dq_o, mem;
  logic req_ready_o, wr_data_take_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, dq_oe_o;
  logic [7:0] beats, base;
  logic [10:0] rows [12];
  int bad_count = 0;
  int checks = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  dwp_ctrl i_dwp_ctrl (.*);
  dwp_dram_model i_dwp_dram_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .burst8_i(burst8_i), .cs_n_i(cs_n_o), .ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
    .we_n_i(we_n_o), .dq_oe_i(dq_oe_o), .bank_i(bank_o), .mask_i(write_mask_pin_o),
    .addr_i(addr_o), .dq_i(dq_o), .open_o(open), .beats_o(beats), .mem_o(mem));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ====
  // Holds the request until taken; caller releases it with idle
  task automatic req(input logic [3:0] c, input logic [1:0] b, input logic a, input logic i);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_bank_i <= b;
    req_addr_i <= {2'h0, a, 10'h000};
    req_interrupt_i <= i;
    @(negedge ref_clk_i);
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 100) bad_count++;
    @(posedge ref_clk_i);
  endtask
  task automatic idle(input int n);
    req_valid_i <= 1'b0;
    req_interrupt_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    rows = '{{C_ACT, 2'h0, 1'b0, 4'h1}, {C_WR, 2'h0, 1'b0, 4'h1}, {C_RD, 2'h0, 1'b0, 4'h1},
      {C_PRE, 2'h0, 1'b0, 4'h0}, {C_ACT, 2'h1, 1'b0, 4'h2}, {C_ACT, 2'h2, 1'b0, 4'h6},
      {C_PRE, 2'h1, 1'b0, 4'h4}, {C_PRE, 2'h1, 1'b1, 4'h0}, {C_ACT, 2'h3, 1'b0, 4'h8},
      {C_WR, 2'h3, 1'b1, 4'h0}, {C_ACT, 2'h3, 1'b0, 4'h8}, {C_RD, 2'h3, 1'b1, 4'h0}};
    repeat (8) @(posedge ref_clk_i);
    chk({cs_n_o, ras_n_o, cas_n_o, we_n_o, dq_oe_o}, {dwp_pkg::CMD_DESEL, 1'b0});
    rst_n_i <= 1'b1;
    idle(1);
    foreach (rows[k]) begin
      req(rows[k][10:7], rows[k][6:5], rows[k][4], 1'b0);
      idle(30);
      chk(open, rows[k][3:0]);
    end
    req(C_ACT, 2'h0, 1'b0, 1'b0);
    base = beats;
    req_cmd_i <= C_WR;
    @(negedge ref_clk_i);
    chk(req_ready_o, 16'h0000);
    @(posedge ref_clk_i);
    req(C_WR, 2'h0, 1'b0, 1'b0);
    req(C_WR, 2'h0, 1'b0, 1'b0);
    req(C_RD, 2'h0, 1'b0, 1'b0);
    idle(30);
    chk(beats - base, 8'h04);
    chk(mem, 16'ha500);
    burst8_i <= 1'b1;
    wr_data_i <= 16'h3c96;
    wr_mask_i <= 2'h2;
    base = beats;
    req(C_WR, 2'h0, 1'b0, 1'b0);
    req(C_WR, 2'h0, 1'b1, 1'b1);
    idle(40);
    chk(beats - base, 8'h06);
    chk(mem, 16'ha596);
    chk(open, 4'h0);
    req(C_ACT, 2'h1, 1'b0, 1'b0);
    req(C_RD, 2'h1, 1'b1, 1'b0);
    idle(2);
    chk(open, 4'h2);
    idle(20);
    chk(open, 4'h0);
    rst_n_i <= 1'b0;
    idle(2);
    chk({cs_n_o, ras_n_o, cas_n_o, we_n_o, dq_oe_o}, {dwp_pkg::CMD_DESEL, 1'b0});
    rst_n_i <= 1'b1;
    idle(2);
    report_and_stop();
  end
endmodule // tb_top
